// File: sppe_decode.sv
`timescale 1ns/1ps
`include "sppe_regs.svh"
// Opcode to instruction kind
module sppe_decode (
  input wire logic [7:0] opcode_in,            // Opcode byte
  output sppe_pkg::sppe_kind_type kind_out     // Decoded kind
);
  // Anything outside the six opcodes is flagged illegal
  always_comb begin
    unique case (opcode_in)
      `SPPE_OPC_POP_DIR: kind_out = sppe_pkg::K_POP_DIR;
      `SPPE_OPC_POP_IND: kind_out = sppe_pkg::K_POP_IND;
      `SPPE_OPC_USP_DEC: kind_out = sppe_pkg::K_USP_DEC;
      `SPPE_OPC_USP_INC: kind_out = sppe_pkg::K_USP_INC;
      `SPPE_OPC_PUSH_DIR: kind_out = sppe_pkg::K_PUSH_DIR;
      `SPPE_OPC_PUSH_IND: kind_out = sppe_pkg::K_PUSH_IND;
      default: kind_out = sppe_pkg::K_ILLEGAL;
    endcase
  end
endmodule

// File: sppe_exec.sv
`timescale 1ns/1ps
`include "sppe_regs.svh"
module sppe_exec (
  input wire logic mclk_in,            // Core clock, 10 MHz
  input wire logic rst_b_in,           // Asynchronous reset, active low
  input wire logic psel_in,            // APB select
  input wire logic penable_in,         // APB enable
  input wire logic pwrite_in,          // APB direction, high for write
  input wire logic [11:0] paddr_in,    // APB byte address
  input wire logic [31:0] pwdata_in,   // APB write data
  output logic [31:0] prdata_out,      // APB read data
  output logic pready_out,             // APB ready
  output logic pslverr_out,            // APB error, unmapped index
  output logic busy_out                // Instruction in progress
);
  typedef enum logic {ST_IDLE, ST_EXEC} sppe_state_type;

  sppe_state_type state_q;             // Engine state
  logic [2:0] step_q;                  // Cycle within an instruction
  sppe_pkg::sppe_kind_type kind_q;     // Kind being executed
  sppe_pkg::sppe_kind_type kind_dec;   // Kind of the opcode on the bus
  sppe_pkg::sppe_instr_type instr_q;   // Latched instruction bytes
  sppe_pkg::sppe_instr_type instr_bus; // Instruction view of write data
  logic [15:0] sp_q;                   // Stack pointer
  logic [7:0] ptr_q;                   // Address fetched from a pointer register
  logic [7:0] data_q;                  // Byte in transit
  logic ill_q;                         // Last start had an illegal opcode
  logic [7:0] last_opc_q;              // Last opcode started
  logic rd_wait_q;                     // Bus read waits for register data
  logic sp_hit_q;                      // Last read hit a stack pointer byte
  logic [7:0] sp_byte_q;               // That byte, taken at read time
  logic [9:0] idx;                     // Register index
  logic apb_take;                      // Bus access taken this cycle
  logic start;                         // Instruction write taken
  logic [7:0] rd_raw;                  // Register file read data
  logic [7:0] rd_view;                 // Read data with the pointer bytes overlaid
  logic rd_en;                         // Muxed read request
  logic [7:0] rd_addr;                 // Muxed read address
  sppe_pkg::sppe_mem_wr_type wr;       // Muxed write request
  logic x_rd_en;                       // Engine read request
  logic [7:0] x_rd_addr;               // Engine read address
  sppe_pkg::sppe_mem_wr_type x_wr;     // Engine write request
  logic cap_ptr;                       // Take read data as pointer
  logic cap_data;                      // Take read data as the moved byte
  logic sp_inc;                        // Stack pointer plus one
  logic sp_dec;                        // Stack pointer minus one

  assign idx = paddr_in[11:2];
  assign instr_bus = pwdata_in[23:0];
  // Bus waits while an instruction runs, so the engine owns the port then
  assign apb_take = psel_in & penable_in & ~pready_out & ~rd_wait_q & ~busy_out;
  assign start = apb_take & pwrite_in & (idx == `SPPE_IDX_INSTR);
  assign rd_view = sp_hit_q ? sp_byte_q : rd_raw;

  sppe_decode u_decode (
    .opcode_in(instr_bus.opcode),
    .kind_out(kind_dec)
  );

  sppe_regfile u_regfile (
    .mclk_in(mclk_in),
    .rd_en_in(rd_en),
    .rd_addr_in(rd_addr),
    .wr_in(wr),
    .rd_data_out(rd_raw)
  );

  // Engine steps; reads return one cycle later, so captures sit one step after
  // Only register-file ports, captures and stack pointer steps are driven: there is no path to a flag register
  always_comb begin
    x_rd_en = 1'b0;
    x_rd_addr = 8'h00;
    x_wr = '0;
    cap_ptr = 1'b0;
    cap_data = 1'b0;
    sp_inc = 1'b0;
    sp_dec = 1'b0;
    if (state_q == ST_EXEC) begin
      unique case (kind_q)
        sppe_pkg::K_POP_DIR: begin
          x_rd_en = (step_q == 3'h0);
          x_rd_addr = sp_q[7:0];
          cap_data = (step_q == 3'h1);
          x_wr = '{en: step_q == 3'h2, addr: instr_q.byte1, data: data_q};
          sp_inc = (step_q == 3'h3);
        end
        sppe_pkg::K_POP_IND: begin
          x_rd_en = (step_q == 3'h0) | (step_q == 3'h1);
          x_rd_addr = (step_q == 3'h0) ? sp_q[7:0] : instr_q.byte1;
          cap_data = (step_q == 3'h1);
          cap_ptr = (step_q == 3'h2);
          x_wr = '{en: step_q == 3'h3, addr: ptr_q, data: data_q};
          sp_inc = (step_q == 3'h4);
        end
        sppe_pkg::K_USP_DEC, sppe_pkg::K_USP_INC: begin
          x_rd_en = (step_q == 3'h0) | (step_q == 3'h2);
          x_rd_addr = (step_q == 3'h0) ? instr_q.byte1 : ptr_q;
          cap_ptr = (step_q == 3'h1);
          cap_data = (step_q == 3'h3);
          if (step_q == 3'h4) begin
            x_wr = '{en: 1'b1, addr: instr_q.byte2, data: data_q};
          end else if (step_q == 3'h5) begin
            x_wr.en = 1'b1;
            x_wr.addr = instr_q.byte1;
            x_wr.data = (kind_q == sppe_pkg::K_USP_DEC) ? ptr_q - 8'h01 : ptr_q + 8'h01;
          end
        end
        sppe_pkg::K_PUSH_DIR: begin
          sp_dec = (step_q == 3'h0);
          x_rd_en = (step_q == 3'h1);
          x_rd_addr = instr_q.byte1;
          cap_data = (step_q == 3'h2);
          x_wr = '{en: step_q == 3'h3, addr: sp_q[7:0], data: data_q};
        end
        sppe_pkg::K_PUSH_IND: begin
          sp_dec = (step_q == 3'h0);
          x_rd_en = (step_q == 3'h0) | (step_q == 3'h2);
          x_rd_addr = (step_q == 3'h0) ? instr_q.byte1 : ptr_q;
          cap_ptr = (step_q == 3'h1);
          cap_data = (step_q == 3'h3);
          x_wr = '{en: step_q == 3'h4, addr: sp_q[7:0], data: data_q};
        end
        sppe_pkg::K_ILLEGAL: begin
          x_rd_en = 1'b0;
        end
      endcase
    end
  end

  // Port mux: engine while busy, bus otherwise
  always_comb begin
    if (busy_out) begin
      rd_en = x_rd_en;
      rd_addr = x_rd_addr;
      wr = x_wr;
    end else begin
      rd_en = apb_take & ~pwrite_in & (idx <= `SPPE_RF_LAST);
      rd_addr = idx[7:0];
      wr.en = apb_take & pwrite_in & (idx <= `SPPE_RF_LAST);
      wr.addr = idx[7:0];
      wr.data = pwdata_in[7:0];
    end
  end

  // Engine state and step counter: every instruction lasts 8 cycles
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
      step_q <= 3'h0;
      busy_out <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start && kind_dec != sppe_pkg::K_ILLEGAL) begin
            state_q <= ST_EXEC;
            busy_out <= 1'b1;
            step_q <= 3'h0;
          end
        end
        ST_EXEC: begin
          step_q <= step_q + 3'h1;
          if (step_q == `SPPE_STEP_LAST) begin
            state_q <= ST_IDLE;
            busy_out <= 1'b0;
          end
        end
      endcase
    end
  end

  // Instruction latch and start status; an illegal opcode never runs
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      instr_q <= '0;
      kind_q <= sppe_pkg::K_ILLEGAL;
      ill_q <= 1'b0;
      last_opc_q <= 8'h00;
    end else if (start) begin
      instr_q <= instr_bus;
      kind_q <= kind_dec;
      ill_q <= (kind_dec == sppe_pkg::K_ILLEGAL);
      last_opc_q <= instr_bus.opcode;
    end
  end

  // Operand captures
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr_q <= 8'h00;
      data_q <= 8'h00;
    end else begin
      if (cap_ptr) begin
        ptr_q <= rd_view;
      end
      if (cap_data) begin
        data_q <= rd_view;
      end
    end
  end

  // Stack pointer: a write to its register index wins over the engine step
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sp_q <= `SPPE_SP_RST;
    end else if (wr.en && {2'b00, wr.addr} == `SPPE_IDX_SPH) begin
      sp_q[15:8] <= wr.data;
    end else if (wr.en && {2'b00, wr.addr} == `SPPE_IDX_SPL) begin
      sp_q[7:0] <= wr.data;
    end else if (sp_inc) begin
      sp_q <= sp_q + 16'h0001;
    end else if (sp_dec) begin
      sp_q <= sp_q - 16'h0001;
    end
  end

  // Reads of D8/D9 return the live pointer byte, not the shadowed storage
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sp_hit_q <= 1'b0;
      sp_byte_q <= 8'h00;
    end else if (rd_en) begin
      sp_hit_q <= ({2'b00, rd_addr} == `SPPE_IDX_SPH) || ({2'b00, rd_addr} == `SPPE_IDX_SPL);
      sp_byte_q <= ({2'b00, rd_addr} == `SPPE_IDX_SPH) ? sp_q[15:8] : sp_q[7:0];
    end
  end

  // Bus answer: register-file reads take one extra cycle for the data
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
      rd_wait_q <= 1'b0;
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      if (rd_wait_q) begin
        rd_wait_q <= 1'b0;
        pready_out <= 1'b1;
        prdata_out <= {24'h000000, rd_view};
      end else if (apb_take) begin
        if (!pwrite_in && idx <= `SPPE_RF_LAST) begin
          rd_wait_q <= 1'b1;
        end else begin
          pready_out <= 1'b1;
          pslverr_out <= (idx > `SPPE_IDX_STAT);
          prdata_out <= 32'h00000000;
          if (!pwrite_in && idx == `SPPE_IDX_INSTR) begin
            prdata_out <= {8'h00, instr_q};
          end else if (!pwrite_in && idx == `SPPE_IDX_STAT) begin
            prdata_out[`SPPE_STAT_BUSY] <= busy_out;
            prdata_out[`SPPE_STAT_ILL] <= ill_q;
            prdata_out[`SPPE_STAT_OPC_LO +: 8] <= last_opc_q;
          end
        end
      end
    end
  end

  // Checks
  sequence s_pop_store;
    wr.en && wr.addr == instr_q.byte1 ##1 sp_inc;
  endsequence
  sequence s_push_store;
    sp_dec ##3 (wr.en && wr.addr == sp_q[7:0]);
  endsequence

  a_instr_eight_cycles: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (start && kind_dec != sppe_pkg::K_ILLEGAL) |=> busy_out [*8] ##1 !busy_out)
    else $error("instruction did not last 8 cycles");
  a_pop_store_first: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (start && kind_dec == sppe_pkg::K_POP_DIR) |=> ##2 s_pop_store)
    else $error("pop did not store before incrementing");
  a_pop_sp_plus: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (start && kind_dec == sppe_pkg::K_POP_IND) |=> ##8 (sp_q == $past(sp_q, 8) + 16'h0001))
    else $error("pop did not add one to the stack pointer");
  a_push_dec_first: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (start && kind_dec == sppe_pkg::K_PUSH_DIR) |=> s_push_store)
    else $error("push did not decrement before storing");
  a_push_sp_wrap: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (start && (kind_dec == sppe_pkg::K_PUSH_DIR || kind_dec == sppe_pkg::K_PUSH_IND) && sp_q == 16'h0000)
      |=> ##8 (sp_q == 16'hFFFF))
    else $error("stack pointer did not wrap to all ones");
  a_user_dec_ptr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (start && kind_dec == sppe_pkg::K_USP_DEC) |=> ##4 (wr.en && wr.addr == instr_q.byte2)
      ##1 (wr.en && wr.addr == instr_q.byte1 && wr.data == ptr_q - 8'h01))
    else $error("decrementing user pop out of order");
  a_user_inc_ptr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (start && kind_dec == sppe_pkg::K_USP_INC) |=> ##4 (wr.en && wr.addr == instr_q.byte2 && wr.data == data_q)
      ##1 (wr.en && wr.addr == instr_q.byte1 && wr.data == ptr_q + 8'h01))
    else $error("incrementing user pop out of order");
  a_sp_high_map: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (apb_take && pwrite_in && idx == `SPPE_IDX_SPH) |=> (sp_q[15:8] == $past(pwdata_in[7:0])))
    else $error("write to pointer high byte lost");
  a_ind_ptr_use: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (busy_out && kind_q == sppe_pkg::K_POP_IND && step_q == 3'h3) |-> (wr.addr == ptr_q && wr.en))
    else $error("indirect pop wrote past its pointer");
endmodule

// File: sppe_pkg.sv
package sppe_pkg;
  // Decoded instruction kinds
  typedef enum logic [2:0] {
    K_ILLEGAL,
    K_POP_DIR,
    K_POP_IND,
    K_USP_DEC,
    K_USP_INC,
    K_PUSH_DIR,
    K_PUSH_IND
  } sppe_kind_type;
  // Instruction as written by software: opcode in the low byte
  typedef struct packed {
    logic [7:0] byte2;
    logic [7:0] byte1;
    logic [7:0] opcode;
  } sppe_instr_type;
  // One register-file write
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } sppe_mem_wr_type;
endpackage

// File: sppe_ref_model.sv
`timescale 1ns/1ps
// Far-side model: register file and stack pointer as software sees them
module sppe_ref_model;
  logic [7:0] mem [0:255]; // Shadow register file
  logic [15:0] stack_ptr; // Shadow stack pointer
  // Apply one instruction: opcode, byte1, byte2; all reads use pre-instruction values
  task automatic run(input logic [23:0] ins);
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] p;
    b1 = ins[15:8];
    b2 = ins[23:16];
    p = mem[b1];
    case (ins[7:0])
      8'h50: begin // Read top of stack first, then bump pointer
        mem[b1] = mem[stack_ptr[7:0]];
        stack_ptr = stack_ptr + 16'h0001;
      end
      8'h51: begin // Destination reached through a pointer register
        mem[p] = mem[stack_ptr[7:0]];
        stack_ptr = stack_ptr + 16'h0001;
      end
      8'h92, 8'h93: begin // Copy first, then move the user pointer
        mem[b2] = mem[p];
        mem[b1] = ins[0] ? p + 8'h01 : p - 8'h01;
      end
      8'h70, 8'h71: begin // Pointer moves before the store
        stack_ptr = stack_ptr - 16'h0001;
        mem[stack_ptr[7:0]] = ins[0] ? mem[p] : mem[b1];
      end
      default: begin // Unknown opcodes leave all state alone
      end
    endcase
  endtask
endmodule

// File: sppe_regfile.sv
`timescale 1ns/1ps
// 256-byte register file, one registered read port and one write port
module sppe_regfile (
  input wire logic mclk_in,                     // Core clock
  input wire logic rd_en_in,                    // Read request
  input wire logic [7:0] rd_addr_in,            // Read address
  input wire sppe_pkg::sppe_mem_wr_type wr_in,  // Write request
  output logic [7:0] rd_data_out                // Read data, one cycle later
);
  logic [7:0] mem_q [256];  // Storage, no reset: contents are software's

  // Write port
  always_ff @(posedge mclk_in) begin
    if (wr_in.en) begin
      mem_q[wr_in.addr] <= wr_in.data;
    end
  end

  // Read port; old data when reading and writing one word together
  always_ff @(posedge mclk_in) begin
    if (rd_en_in) begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end
endmodule

// File: sppe_regs.svh
`ifndef SPPE_REGS_SVH
`define SPPE_REGS_SVH
// Register indices; byte address on the bus is four times the index
`define SPPE_IDX_SPH 10'h0D8
`define SPPE_IDX_SPL 10'h0D9
`define SPPE_IDX_INSTR 10'h100
`define SPPE_IDX_STAT 10'h101
// Last register file index in words
`define SPPE_RF_LAST 10'h0FF
// Opcodes
`define SPPE_OPC_POP_DIR 8'h50
`define SPPE_OPC_POP_IND 8'h51
`define SPPE_OPC_USP_DEC 8'h92
`define SPPE_OPC_USP_INC 8'h93
`define SPPE_OPC_PUSH_DIR 8'h70
`define SPPE_OPC_PUSH_IND 8'h71
// Instruction length in cycles, and last value of the step counter
`define SPPE_INSTR_CYCLES 8
`define SPPE_STEP_LAST 3'h7
// Reset value of the stack pointer
`define SPPE_SP_RST 16'h0000
// Status fields
`define SPPE_STAT_BUSY 0
`define SPPE_STAT_ILL 1
`define SPPE_STAT_OPC_LO 8
`endif

// File: stack_push_pop_exec_tb.sv
`timescale 1ns/1ps
`include "sppe_regs.svh"
module stack_push_pop_exec_tb;
  logic mclk_in = 1'b0; // Core clock
  logic rst_b_in = 1'b0; // Reset, active low
  logic psel = 1'b0; // Bus select
  logic penable = 1'b0; // Bus enable
  logic pwrite = 1'b0; // Bus direction
  logic [11:0] paddr = 12'h000; // Byte address
  logic [31:0] pwdata = 32'h00000000; // Write data
  logic [31:0] prdata; // Read data
  logic pready; // Ready
  logic pslverr; // Error response
  logic busy; // Engine running
  logic [31:0] rd; // Data of last transfer
  logic err; // Error of last transfer
  int miscompares = 0; // Failed comparisons
  int checks_done = 0; // All comparisons
  int busy_len = 0; // Length of the current busy run
  int busy_runs = 0; // Completed busy runs
  int runs_before; // Busy runs before the illegal opcodes
  logic [7:0] ill [2] = '{8'h82, 8'h00}; // Opcodes outside this unit

  sppe_ref_model ref_m ();

  sppe_exec dut (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .psel_in(psel),
    .penable_in(penable),
    .pwrite_in(pwrite),
    .paddr_in(paddr),
    .pwdata_in(pwdata),
    .prdata_out(prdata),
    .pready_out(pready),
    .pslverr_out(pslverr),
    .busy_out(busy)
  );

  // Free-running clock, 100 ns period
  always #50 mclk_in = ~mclk_in;

  // Single exit point of the run
  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Compare with case equality so an unknown matches only an unknown in the expected value
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // One bus transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin // Stalled bus counts as a failure
      miscompares++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a register and compare
  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000);
    check(rd, exp);
  endtask

  // Write one file byte in design and model alike; upper data bits must be ignored
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    ref_m.mem[a] = v;
    apb(1'b1, {2'b00, a}, {24'hFFFFFF, v});
  endtask

  // Run one instruction; the first read is stalled until the engine is idle
  task automatic exec(input logic [23:0] ins);
    apb(1'b1, `SPPE_IDX_INSTR, {8'h00, ins});
    ref_m.run(ins);
    rdchk(`SPPE_IDX_SPL, {24'h000000, ref_m.stack_ptr[7:0]});
    rdchk(`SPPE_IDX_SPH, {24'h000000, ref_m.stack_ptr[15:8]});
    for (int i = 0; i < 256; i++) begin
      if (i != `SPPE_IDX_SPH && i != `SPPE_IDX_SPL) begin
        rdchk(10'(i), {24'h000000, ref_m.mem[i]});
      end
    end
  endtask

  // Every busy run must last the documented instruction length
  always @(posedge mclk_in) begin
    if (busy === 1'b1) begin
      busy_len++;
    end else if (busy_len != 0) begin
      check(32'(busy_len), 32'(`SPPE_INSTR_CYCLES));
      busy_runs++;
      busy_len = 0;
    end
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rdchk(`SPPE_IDX_SPH, 32'h00000000);
    rdchk(`SPPE_IDX_SPL, 32'h00000000);
    // Known pattern everywhere except the pointer bytes
    for (int i = 0; i < 256; i++) begin
      if (i != `SPPE_IDX_SPH && i != `SPPE_IDX_SPL) begin
        put(8'(i), 8'(i) ^ 8'h5A);
      end
    end
    put(8'h10, 8'h00); // User pointer at the low boundary
    put(8'h30, 8'hFF); // User pointer at the high boundary
    ref_m.stack_ptr = 16'h0000;
    exec(24'h004070);
    exec(24'h004071);
    exec(24'h000050);
    exec(24'h000151);
    exec(24'h201092);
    exec(24'h313093);
    // Pointer loaded by software through its two byte registers
    apb(1'b1, `SPPE_IDX_SPH, 32'h00000000);
    apb(1'b1, `SPPE_IDX_SPL, 32'h000000FB);
    ref_m.stack_ptr = 16'h00FB;
    exec(24'h000250);
    // Unknown opcodes set the status flag and never start the engine
    runs_before = busy_runs;
    foreach (ill[k]) begin
      apb(1'b1, `SPPE_IDX_INSTR, {24'h000000, ill[k]});
      apb(1'b0, `SPPE_IDX_STAT, 32'h00000000);
      check(rd & 32'h0000FF03, {16'h0000, ill[k], 8'h02});
    end
    check(32'(busy_runs), 32'(runs_before));
    // Unmapped places answer with an error and read as zero
    apb(1'b0, 10'h102, 32'h00000000);
    check({31'h00000000, err}, 32'h00000001);
    check(rd, 32'h00000000);
    apb(1'b1, 10'h3FF, 32'hFFFFFFFF);
    check({31'h00000000, err}, 32'h00000001);
    rdchk(`SPPE_IDX_SPL, 32'h000000FC);
    report_and_stop();
  end
endmodule
